//--- otw_defines.svh
// Constants for the one-time enabled watchdog.
// Assumes inclusion by the package and the design modules.
`ifndef OTW_DEFINES_SVH
`define OTW_DEFINES_SVH
`define OTW_KEY_ADDR      8'ha6
`define OTW_KEY_FIRST     8'h1e
`define OTW_KEY_SECOND    8'he1
`define OTW_CNT_WIDTH     14
`define OTW_CNT_TERMINAL  14'h3fff
`define OTW_CNT_ZERO      14'h0000
`define OTW_TICK_DIV_FAST 4'h6
`define OTW_TICK_DIV_SLOW 4'hc
`define OTW_PULSE_FAST    8'h62
`define OTW_PULSE_SLOW    8'hc4
`endif

//--- otw_pkg.sv
// Types shared by the watchdog modules.
// Assumes otw_defines.svh is on the include path.
`include "otw_defines.svh"
package otw_pkg;
    // SFR write strobe with its address and data
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } otw_sfr_wr_type;

    // Key sequence progress
    typedef enum logic [0:0] {
        OTW_SEQ_IDLE  = 1'b0,
        OTW_SEQ_FIRST = 1'b1
    } otw_seq_type;
endpackage

//--- otw_pulse_gen.sv
// Fixed-length reset pulse stretcher on the oscillator clock.
// Assumes start is a one-cycle request and clk is the oscillator.
`timescale 1ns/1ps
`include "otw_defines.svh"
module otw_pulse_gen
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    input  wire logic six_clk_mode,
    output logic      active
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // ---------------------------------------------------------------
    // Countdown
    // ---------------------------------------------------------------
    // Loads 98 or 196 oscillator periods; active while nonzero
    always_comb
    begin
        cnt_d = cnt_q;
        if (start && cnt_q == 8'h00)
            cnt_d = six_clk_mode ? `OTW_PULSE_FAST : `OTW_PULSE_SLOW;
        else if (cnt_q != 8'h00)
            cnt_d = cnt_q - 8'h01;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_d;
    end

    assign active = (cnt_q != 8'h00);
endmodule

//--- otw_tick_gen.sv
// Machine-cycle tick from the oscillator clock.
// Assumes clk is the oscillator and osc_run gates it as a stopped clock.
`timescale 1ns/1ps
`include "otw_defines.svh"
module otw_tick_gen
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic osc_run,
    input  wire logic six_clk_mode,
    output logic      tick
);
    logic [3:0] div_q;
    logic [3:0] div_d;
    logic [3:0] last;

    // ---------------------------------------------------------------
    // Divider
    // ---------------------------------------------------------------
    // Wraps at 6 or 12 oscillator clocks, held while stopped
    always_comb
    begin
        last  = six_clk_mode ? `OTW_TICK_DIV_FAST - 4'h1 : `OTW_TICK_DIV_SLOW - 4'h1;
        div_d = div_q;
        tick  = 1'b0;
        if (osc_run)
        begin
            if (div_q >= last)
            begin
                div_d = 4'h0;
                tick  = 1'b1;
            end
            else
            begin
                div_d = div_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            div_q <= 4'h0;
        else
            div_q <= div_d;
    end
endmodule

//--- otw_watchdog.sv
// One-time enabled watchdog with reset-out drive.
// Assumes SFR writes arrive as one-cycle strobes on the oscillator clock.
`timescale 1ns/1ps
`include "otw_defines.svh"
module otw_watchdog
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire otw_pkg::otw_sfr_wr_type sfr_wr,
    input  wire logic                   osc_run,
    input  wire logic                   six_clk_mode,
    output logic                        armed,
    output logic                        wdt_reset_req,
    output logic                        rst_pin_out,
    output logic                        rst_pin_oe
);
    logic                       armed_q;
    logic                       armed_d;
    logic [`OTW_CNT_WIDTH-1:0]  cnt_q;
    logic [`OTW_CNT_WIDTH-1:0]  cnt_d;
    otw_pkg::otw_seq_type       seq_q;
    otw_pkg::otw_seq_type       seq_d;
    logic                       ovf_q;
    logic                       ovf_d;
    logic                       tick;
    logic                       key_hit;
    logic                       pair_done;
    logic                       pulse_active;

    // ---------------------------------------------------------------
    // Machine-cycle tick
    // ---------------------------------------------------------------
    // Tick divider select
    otw_tick_gen u_tick
    (
        .clk          (clk),
        .arst_n       (arst_n),
        .osc_run      (osc_run),
        .six_clk_mode (six_clk_mode),
        .tick         (tick)
    );

    // ---------------------------------------------------------------
    // Key sequence
    // ---------------------------------------------------------------
    // Write-only decode; nothing is returned on reads
    assign key_hit = sfr_wr.wr && (sfr_wr.addr == `OTW_KEY_ADDR);

    // Only writes to the key address move the sequence, other SFRs ignored
    always_comb
    begin
        seq_d     = seq_q;
        pair_done = 1'b0;
        if (key_hit)
        begin
            unique case (seq_q)
                otw_pkg::OTW_SEQ_IDLE:
                begin
                    if (sfr_wr.data == `OTW_KEY_FIRST)
                        seq_d = otw_pkg::OTW_SEQ_FIRST;
                end
                otw_pkg::OTW_SEQ_FIRST:
                begin
                    if (sfr_wr.data == `OTW_KEY_SECOND)
                    begin
                        pair_done = 1'b1;
                        seq_d     = otw_pkg::OTW_SEQ_IDLE;
                    end
                    else if (sfr_wr.data == `OTW_KEY_FIRST)
                        seq_d = otw_pkg::OTW_SEQ_FIRST;   // Restart on a fresh first byte
                    else
                        seq_d = otw_pkg::OTW_SEQ_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Arm flag, counter and overflow
    // ---------------------------------------------------------------
    // Overflow wins over a same-cycle service so a late key cannot mask it
    always_comb
    begin
        armed_d = armed_q;
        cnt_d   = cnt_q;
        ovf_d   = 1'b0;
        if (pair_done)
            armed_d = 1'b1;
        if (armed_q)
        begin
            if (cnt_q == `OTW_CNT_TERMINAL)
            begin
                ovf_d   = 1'b1;
                armed_d = 1'b0;
                cnt_d   = `OTW_CNT_ZERO;
            end
            else if (pair_done)
                cnt_d = `OTW_CNT_ZERO;
            else if (tick)
                cnt_d = cnt_q + `OTW_CNT_WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            armed_q <= 1'b0;
            cnt_q   <= `OTW_CNT_ZERO;
            seq_q   <= otw_pkg::OTW_SEQ_IDLE;
            ovf_q   <= 1'b0;
        end
        else
        begin
            armed_q <= armed_d;
            cnt_q   <= cnt_d;
            seq_q   <= seq_d;
            ovf_q   <= ovf_d;
        end
    end

    // ---------------------------------------------------------------
    // Reset-out pulse
    // ---------------------------------------------------------------
    // Fixed pulse length by timing mode
    otw_pulse_gen u_pulse
    (
        .clk          (clk),
        .arst_n       (arst_n),
        .start        (ovf_q),
        .six_clk_mode (six_clk_mode),
        .active       (pulse_active)
    );

    // Drive reset pin high during pulse
    assign rst_pin_out   = pulse_active;
    assign rst_pin_oe    = pulse_active;
    assign wdt_reset_req = pulse_active;   // Device-wide reset request
    assign armed         = armed_q;
endmodule

//--- otw_watchdog_asserts.sv
// Port checker for the watchdog top module.
// Assumes one clock domain; bound in below.
`timescale 1ns/1ps
module otw_watchdog_asserts
(
    input wire logic                    clk,
    input wire logic                    arst_n,
    input wire otw_pkg::otw_sfr_wr_type sfr_wr,
    input wire logic                    osc_run,
    input wire logic                    six_clk_mode,
    input wire logic                    armed,
    input wire logic                    wdt_reset_req,
    input wire logic                    rst_pin_out,
    input wire logic                    rst_pin_oe
);
    // ----------------
    // Helper state
    // ----------------
    localparam int MIN_RUN = 98293;
    logic        first_q, first_d;
    logic [7:0]  len_q, len_d;
    logic [31:0] run_q, run_d;
    logic        key_w, pair_w;
    assign key_w  = sfr_wr.wr && sfr_wr.addr == 8'ha6;
    assign pair_w = key_w && sfr_wr.data == 8'he1 && first_q;
    // Pending first byte, pulse length, cycles since clear
    always_comb
    begin
        first_d = key_w ? (sfr_wr.data == 8'h1e) : first_q;
        len_d   = rst_pin_out ? len_q + 8'h01 : 8'h00;
        run_d   = pair_w ? 32'h0 : run_q + 32'h1;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            first_q <= 1'b0;
            len_q   <= 8'h00;
            run_q   <= 32'h0;
        end
        else
        begin
            first_q <= first_d;
            len_q   <= len_d;
            run_q   <= run_d;
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    pin_oe_match_a: assert property (rst_pin_oe == rst_pin_out)
        else $error("pin enable differs from pin");
    req_pin_match_a: assert property (wdt_reset_req == rst_pin_out)
        else $error("reset request differs from pin");
    key_pair_arms_a: assert property (pair_w && !armed |=> armed)
        else $error("key pair did not arm");
    stays_off_a: assert property (!armed && !pair_w |=> !armed)
        else $error("armed without key pair");
    disarm_pulse_a: assert property ($fell(armed) |-> ##2 rst_pin_out)
        else $error("disarm without reset pulse");
    pulse_disarmed_a: assert property ($rose(rst_pin_out) |-> !armed)
        else $error("pulse while still armed");
    pulse_length_a: assert property ($fell(rst_pin_out) |->
        len_q == (six_clk_mode ? 8'h62 : 8'hc4))
        else $error("reset pulse length wrong");
    no_early_ovf_a: assert property ($fell(armed) |-> run_q >= MIN_RUN)
        else $error("overflow came too early");
endmodule
bind otw_watchdog otw_watchdog_asserts chk (.clk(clk), .arst_n(arst_n), .sfr_wr(sfr_wr),
    .osc_run(osc_run), .six_clk_mode(six_clk_mode), .armed(armed),
    .wdt_reset_req(wdt_reset_req), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));

//--- tb_top.sv
// Self-checking bench for the watchdog.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic                    clk;
    logic                    arst_n;
    otw_pkg::otw_sfr_wr_type sfr_wr;
    logic                    osc_run;
    logic                    six_clk_mode;
    logic                    armed;
    logic                    wdt_reset_req;
    logic                    rst_pin_out;
    logic                    rst_pin_oe;
    int                      fails, compares, seed, n, r;
    otw_watchdog dut (.clk(clk), .arst_n(arst_n), .sfr_wr(sfr_wr), .osc_run(osc_run),
        .six_clk_mode(six_clk_mode), .armed(armed), .wdt_reset_req(wdt_reset_req),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));
    // Oscillator, 25 ns
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One-cycle write strobe, launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_wr = '{1'b1, a, d};
        @(negedge clk);
        sfr_wr.wr = 1'b0;
    endtask
    // Random byte that is neither key value
    function automatic logic [7:0] rnd_bad();
        logic [7:0] v;
        v = $random(seed);
        return (v == 8'h1e || v == 8'he1) ? 8'h00 : v;
    endfunction
    // Cycles from service to pin rise: ticks, stall, three edges
    function automatic int run_len(input int stall);
        return 6 * 16382 + stall + 3;
    endfunction
    initial
    begin
        seed = 48;
        fails = 0;
        compares = 0;
        arst_n = 1'b0;
        sfr_wr = '0;
        osc_run = 1'b1;
        six_clk_mode = 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        chk(armed, 0);
        wr(8'ha6, 8'he1);
        chk(armed, 0);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, rnd_bad());
        wr(8'ha6, 8'he1);
        chk(armed, 0);
        // Other addresses never count as key writes
        repeat (8)
        begin
            r = $random(seed);
            wr((r[7:0] == 8'ha6) ? 8'h00 : r[7:0], 8'h1e);
            wr(8'ha5, 8'he1);
        end
        chk(armed, 0);
        wr(8'ha6, 8'h1e);
        wr(8'h90, $random(seed));
        wr(8'ha6, 8'he1);
        @(negedge clk);
        chk(armed, 1);
        repeat (8) wr(8'ha6, rnd_bad());
        chk(armed, 1);
        repeat (600) @(negedge clk);
        chk(rst_pin_out, 0);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        // Stopped oscillator holds the count for 300 cycles
        n = 0;
        while (rst_pin_out !== 1'b1 && n < 110000)
        begin
            @(negedge clk);
            n++;
            osc_run = (n >= 1000 && n < 1300) ? 1'b0 : 1'b1;
        end
        if (n >= 110000)
        begin
            fails++;
            end_sim();
        end
        chk(n >= run_len(300) && n <= run_len(300) + 6, 1);
        chk(rst_pin_oe, 1);
        chk(wdt_reset_req, 1);
        n = 0;
        while (rst_pin_out === 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        chk(n, 98);
        chk(armed, 0);
        // Hardware reset in mid-run disarms
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        @(negedge clk) arst_n = 1'b0;
        @(negedge clk) arst_n = 1'b1;
        chk(armed, 0);
        end_sim();
    end
endmodule
